// [adc_ctl_pkg.sv]
// Constants and carrier types for the converter control block.
// Assumes an 8-bit register set on a 32-bit classic Wishbone bus.
`default_nettype none
package adc_ctl_pkg;
    // Register word indices; byte address is four times the index
    localparam logic [3:0] CFG_IDX  = 4'h0;
    localparam logic [3:0] TCS_IDX  = 4'h1;
    localparam logic [3:0] CCC_IDX  = 4'h2;
    localparam logic [3:0] RESH_IDX = 4'h3;
    localparam logic [3:0] RESL_IDX = 4'h4;
    localparam logic [3:0] CMPH_IDX = 4'h5;
    localparam logic [3:0] CMPL_IDX = 4'h6;
    localparam logic [3:0] PIN1_IDX = 4'h7;
    localparam logic [3:0] PIN2_IDX = 4'h8;
    // converter_config fields
    localparam int LPWR_BIT = 7;
    localparam int DIV_LSB  = 5;
    localparam int LSMP_BIT = 4;
    localparam int MODE_LSB = 2;
    localparam int ICLK_LSB = 0;
    // trigger_compare_status fields
    localparam int ACT_BIT  = 7;
    localparam int TRG_BIT  = 6;
    localparam int CMPE_BIT = 5;
    localparam int CMPG_BIT = 4;
    // channel_complete_control fields
    localparam int DONE_BIT = 7;
    localparam int IEN_BIT  = 6;
    localparam int CONT_BIT = 5;
    localparam int CH_LSB   = 0;
    // Reset values
    localparam logic [7:0] REG_RST  = 8'h00;
    localparam logic [7:0] CCC_RST  = 8'h1F;
    // Encodings
    localparam logic [1:0] MODE_10BIT = 2'b10;
    localparam logic [4:0] CHAN_OFF   = 5'h1F;
    // Sample window in half conversion-clock cycles, and whole ticks
    localparam int SHORT_HALVES = 7;
    localparam int LONG_HALVES  = 47;
    localparam logic [4:0] SHORT_TICKS = 5'((SHORT_HALVES + 1) / 2);
    localparam logic [4:0] LONG_TICKS  = 5'((LONG_HALVES + 1) / 2);
    // Bus cycles for the comparator path to settle after a trial step
    localparam logic [2:0] SETTLE_CYC = 3'h5;
    // Wishbone request carrier
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } wb_req_t;
    // Converter sequence states
    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT, ST_FINISH} conv_state_t;
endpackage : adc_ctl_pkg
`default_nettype wire

// [adc_control.sv]
// Converter control: registers, conversion clock, sequencing, SAR, compare.
// Assumes an analog comparator (input >= trial code) and a pin mux outside.
// Functional notes
// - config bit 7 selects low power
// - config bits 6:5 divide; 00 is one
// - config bit 4 selects long sample
// - config bits 3:2 resolution; 10 is 10-bit
// - config bits 1:0 clock source; 00 bus
// - status bits: active, trigger, compare, direction
// - status bits 3:0 always read zero
// - control bit 7 set at conversion end
// - control bit 6 enables completion interrupt
// - bit 5 continuous, else one per trigger
// - control bits 4:0 pick input channel
// - high-then-low read blocks result overwrite
// - compare pair holds value for comparison
// - pin control bit disables pin digital I/O
// - set bit: output high impedance, pullup off
// - conversions allowed without pin bit set
// - inputs beyond references saturate to limits
// - sample window 3.5 or 23.5 clocks; rounded up to 4 or 24 here
// - control write aborts, restarts unless channel off or hardware-triggered
// - interrupt when flag set and enabled
// - other mode writes abort, result kept
`timescale 1ns/10ps
`default_nettype none
module adc_control
    import adc_ctl_pkg::*;
#(
    parameter int RES_W = 10            // Widest result
) (
    // Clock and reset
    input  wire logic              mclk_i,
    input  wire logic              resetn_i,
    // Wishbone slave
    input  wire wb_req_t           wb_req_i,
    output logic [31:0]            wb_dat_o,
    output logic                   wb_ack_o,
    // Clock sources and trigger, same domain
    input  wire logic              alt_ck_en_i,
    input  wire logic              async_ck_en_i,
    input  wire logic              hw_trig_i,
    // Analog front end
    input  wire logic              cmp_i,
    output logic [RES_W-1:0]       dac_code_o,
    output logic                   sample_o,
    output logic [4:0]             channel_o,
    output logic                   low_power_o,
    // Pin control and interrupt
    output logic [15:0]            pin_analog_o,
    output logic                   irq_o
);
    // Registers
    logic [7:0]       cfg_q;          // converter_config
    logic [4:0]       tcs_q;          // trigger_compare_status bits 6:4 kept
    logic [7:0]       ccc_q;          // channel_complete_control, bit 7 unused
    logic             done_q;         // Completion flag
    logic [RES_W-1:0] res_q;          // Result pair
    logic [RES_W-1:0] cmpv_q;         // Compare pair
    logic [7:0]       pin1_q;
    logic [7:0]       pin2_q;
    logic             lock_q;         // Result blocked after high read
    // Bus decode
    logic       acc;
    logic       wr;
    logic       rd;
    logic [3:0] idx;
    logic [7:0] wd;
    assign acc = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
    assign idx = wb_req_i.adr[5:2];
    assign wd  = wb_req_i.dat[7:0];
    assign wr  = acc & wb_req_i.we & wb_req_i.sel[0] & (wb_req_i.adr[7:6] == 2'b00);
    assign rd  = acc & ~wb_req_i.we & (wb_req_i.adr[7:6] == 2'b00);
    logic wr_ccc;
    logic wr_mode;
    logic rd_high;
    logic rd_low;
    assign wr_ccc  = wr & (idx == CCC_IDX);
    // Any mode change invalidates the running conversion
    assign wr_mode = wr & (idx == CFG_IDX || idx == TCS_IDX ||
                           idx == CMPH_IDX || idx == CMPL_IDX);
    assign rd_high = rd & (idx == RESH_IDX);
    assign rd_low  = rd & (idx == RESL_IDX);
    // Sequencer state
    conv_state_t      st_q;
    logic [4:0]       smp_q;          // Sample tick count
    logic [2:0]       stl_q;          // Settle count
    logic [3:0]       bit_q;          // Bit under trial
    logic [RES_W-1:0] code_q;         // Trial code
    logic             fin_ok;         // Finished result may be kept
    logic [RES_W:0]   diff;           // Result minus compare, with borrow
    logic             cond;
    // Classic single-cycle ack; unmapped addresses still answer
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= acc;
        end
    end
    // Read data captured with the ack
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (rd) begin
            wb_dat_o <= 32'h0000_0000;
            unique case (idx)
                CFG_IDX:  wb_dat_o[7:0] <= cfg_q;
                // Reserved bits read zero
                TCS_IDX:  wb_dat_o[7:0] <= {st_q != ST_IDLE, tcs_q[2:0], 4'h0};
                CCC_IDX:  wb_dat_o[7:0] <= {done_q, ccc_q[6:0]};
                RESH_IDX: wb_dat_o[7:0] <= {6'h00, res_q[9:8]};
                RESL_IDX: wb_dat_o[7:0] <= res_q[7:0];
                CMPH_IDX: wb_dat_o[7:0] <= {6'h00, cmpv_q[9:8]};
                CMPL_IDX: wb_dat_o[7:0] <= cmpv_q[7:0];
                PIN1_IDX: wb_dat_o[7:0] <= pin1_q;
                PIN2_IDX: wb_dat_o[7:0] <= pin2_q;
                default:  wb_dat_o[7:0] <= 8'h00;
            endcase
        end
    end
    // Software-written configuration
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cfg_q  <= REG_RST;
            tcs_q  <= REG_RST[4:0];
            ccc_q  <= CCC_RST;
            cmpv_q <= '0;
            pin1_q <= REG_RST;
            pin2_q <= REG_RST;
        end else if (wr) begin
            unique case (idx)
                CFG_IDX:  cfg_q  <= wd;
                // Low status bits are reserved and dropped
                TCS_IDX:  tcs_q  <= {2'b00, wd[6:4]};
                CCC_IDX:  ccc_q  <= {1'b0, wd[6:0]};
                CMPH_IDX: cmpv_q[9:8] <= wd[1:0];
                CMPL_IDX: cmpv_q[7:0] <= wd;
                PIN1_IDX: pin1_q <= wd;
                PIN2_IDX: pin2_q <= wd;
                default:  cfg_q  <= cfg_q;
            endcase
        end
    end
    // Pin buffers off and pullups off per set bit; no gating of conversion
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_analog_o <= 16'h0000;
        end else begin
            pin_analog_o <= {pin2_q, pin1_q};
        end
    end
    // Conversion clock: source select then divide by 1, 2, 4 or 8
    logic       src_en;
    logic       half_q;               // Bus clock divided by two
    logic [2:0] div_q;
    logic       ck_en;
    logic       start;                // Hardware trigger accepted
    always_comb begin
        unique case (cfg_q[ICLK_LSB +: 2])
            2'b00:   src_en = 1'b1;
            2'b01:   src_en = half_q;
            2'b10:   src_en = alt_ck_en_i;
            default: src_en = async_ck_en_i;
        endcase
    end
    // Divider restarts on a mode write so a new ratio takes effect cleanly,
    // and on a control write or a hardware start from idle, not on a continuous repeat, so the sample window spans whole conversion ticks
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            half_q <= 1'b0;
            div_q  <= 3'h0;
        end else begin
            half_q <= ~half_q;
            if (wr_mode || wr_ccc || (st_q == ST_IDLE && start)) begin
                div_q <= 3'h0;
            end else if (src_en) begin
                div_q <= div_q + 3'h1;
            end
        end
    end
    // Ratio is two to the field value; code 00 passes every source pulse
    always_comb begin
        unique case (cfg_q[DIV_LSB +: 2])
            2'b00:   ck_en = src_en;
            2'b01:   ck_en = src_en & div_q[0];
            2'b10:   ck_en = src_en & (&div_q[1:0]);
            default: ck_en = src_en & (&div_q);
        endcase
    end
    // Low power lowers the permitted conversion clock; flag goes to analog
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            low_power_o <= 1'b0;
        end else begin
            low_power_o <= cfg_q[LPWR_BIT];
        end
    end
    // Comparator synchroniser; a change counts when stages two and three agree
    logic cs1_q;
    logic cs2_q;
    logic cs3_q;
    logic cmp_f_q;
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cs1_q   <= 1'b0;
            cs2_q   <= 1'b0;
            cs3_q   <= 1'b0;
            cmp_f_q <= 1'b0;
        end else begin
            cs1_q <= cmp_i;
            cs2_q <= cs1_q;
            cs3_q <= cs2_q;
            if (cs2_q == cs3_q) begin
                cmp_f_q <= cs3_q;
            end
        end
    end
    // Compare against the stored value
    logic       ten_bit;
    logic [4:0] smp_len;
    assign ten_bit = (cfg_q[MODE_LSB +: 2] == MODE_10BIT);
    assign smp_len = cfg_q[LSMP_BIT] ? LONG_TICKS : SHORT_TICKS;
    assign diff    = {1'b0, code_q} - {1'b0, cmpv_q};
    assign cond    = tcs_q[CMPG_BIT - 4] ? ~diff[RES_W] : diff[RES_W];
    // Blocked result or failed compare discards the conversion
    assign fin_ok  = ~lock_q & (~tcs_q[CMPE_BIT - 4] | cond);
    // Hardware trigger only while idle and hardware-triggered
    assign start   = tcs_q[TRG_BIT - 4] & hw_trig_i & (ccc_q[4:0] != CHAN_OFF);
    // Sequencer; control and mode writes take priority over the state steps
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q <= ST_IDLE;
        end else if (wr_ccc) begin
            // Restart from software trigger unless the channel is off
            st_q <= (wd[4:0] != CHAN_OFF && !tcs_q[TRG_BIT - 4]) ? ST_SAMPLE : ST_IDLE;
        end else if (wr_mode) begin
            st_q <= ST_IDLE;
        end else begin
            unique case (st_q)
                ST_IDLE:    if (start) st_q <= ST_SAMPLE;
                ST_SAMPLE:  if (ck_en && smp_q == smp_len - 5'd1) st_q <= ST_CONVERT;
                ST_CONVERT: if (ck_en && stl_q == 3'h0 && bit_q == 4'h0) st_q <= ST_FINISH;
                // Continuous keeps cycling, single stops after one
                ST_FINISH:  st_q <= ccc_q[CONT_BIT] ? ST_SAMPLE : ST_IDLE;
            endcase
        end
    end
    // Sample window and successive approximation datapath
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            smp_q  <= 5'h00;
            stl_q  <= 3'h0;
            bit_q  <= 4'h0;
            code_q <= '0;
        end else if (st_q == ST_SAMPLE) begin
            if (wr_ccc || wr_mode) begin
                smp_q <= 5'h00;
            end else if (ck_en) begin
                smp_q <= smp_q + 5'h01;
            end
            // Load the top trial bit for the selected resolution
            bit_q  <= ten_bit ? 4'd9 : 4'd7;
            code_q <= ten_bit ? 10'h200 : 10'h080;
            stl_q  <= SETTLE_CYC;
        end else if (st_q == ST_CONVERT) begin
            smp_q <= 5'h00;
            if (stl_q != 3'h0) begin
                stl_q <= stl_q - 3'h1;
            end else if (ck_en) begin
                // Keep the bit only when input is at or above the trial;
                // beyond either reference the code runs to all ones or zero
                code_q[bit_q] <= cmp_f_q;
                if (bit_q != 4'h0) begin
                    code_q[bit_q - 4'h1] <= 1'b1;
                    bit_q <= bit_q - 4'h1;
                end
                stl_q <= SETTLE_CYC;
            end
        end else begin
            smp_q <= 5'h00;
        end
    end
    // Result transfer and read-order lock
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            res_q  <= '0;
            lock_q <= 1'b0;
        end else begin
            // A finish cut by a write in the same cycle is not a success
            if (st_q == ST_FINISH && fin_ok && !wr_ccc && !wr_mode) begin
                res_q <= tcs_q[CMPE_BIT - 4] ? diff[RES_W-1:0] : code_q;
            end
            // Aborts leave the last good result untouched
            if (rd_high) begin
                lock_q <= 1'b1;
            end else if (rd_low) begin
                lock_q <= 1'b0;
            end
        end
    end
    // Completion flag; a set in the same cycle as a clear wins
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            done_q <= 1'b0;
        end else if (st_q == ST_FINISH && fin_ok && !wr_ccc && !wr_mode) begin
            done_q <= 1'b1;
        end else if (wr_ccc || rd_low) begin
            done_q <= 1'b0;
        end
    end
    // Interrupt and analog-facing outputs
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_o      <= 1'b0;
            sample_o   <= 1'b0;
            dac_code_o <= '0;
            channel_o  <= CCC_RST[4:0];
        end else begin
            irq_o      <= done_q & ccc_q[IEN_BIT];
            sample_o   <= (st_q == ST_SAMPLE);
            dac_code_o <= code_q;
            channel_o  <= ccc_q[4:0];
        end
    end
    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    sequence good_finish_s;
        st_q == ST_FINISH && fin_ok && !wr_ccc && !wr_mode;
    endsequence
    sequence flag_seen_s;
        done_q ##1 irq_o == ccc_q[IEN_BIT];
    endsequence
    ack_single_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held more than one cycle");
    flag_on_finish_a: assert property (good_finish_s |=> flag_seen_s)
        else $error("finish did not set flag and interrupt");
    irq_enable_gate_a: assert property (!ccc_q[IEN_BIT] ##1 !ccc_q[IEN_BIT] |-> !irq_o)
        else $error("interrupt raised while disabled");
    ctrl_write_restart_a: assert property (wr_ccc && wd[4:0] != CHAN_OFF
        && !tcs_q[TRG_BIT - 4] |=> st_q == ST_SAMPLE && smp_q == 5'h00)
        else $error("control write did not restart");
    mode_write_abort_a: assert property (wr_mode && !wr_ccc |=> st_q == ST_IDLE
        && $stable(res_q))
        else $error("mode write did not abort cleanly");
    locked_result_a: assert property (lock_q && !rd_low |=> $stable(res_q))
        else $error("result changed while blocked");
    status_reserved_a: assert property (rd && idx == TCS_IDX |=> wb_dat_o[3:0] == 4'h0)
        else $error("reserved status bits not zero");
    sample_length_a: assert property ($rose(sample_o) |-> ##1 smp_q < smp_len)
        else $error("sample window overran");
    clear_on_low_a: assert property (rd_low && st_q != ST_FINISH |=> !done_q)
        else $error("low read did not clear flag");
    pin_mirror_a: assert property (wr && idx == PIN1_IDX |=> ##1 pin_analog_o[7:0] == $past(wd, 2))
        else $error("pin control not applied");
    // End of a conversion: stop after one, or go round again
    sequence finish_single_s;
        st_q == ST_FINISH && !ccc_q[CONT_BIT] && !wr_ccc && !wr_mode;
    endsequence
    sequence finish_cont_s;
        st_q == ST_FINISH && ccc_q[CONT_BIT] && !wr_ccc && !wr_mode;
    endsequence
    single_stop_a: assert property (finish_single_s |=> st_q == ST_IDLE)
        else $error("single conversion did not stop");
    cont_repeat_a: assert property (finish_cont_s |=> st_q == ST_SAMPLE)
        else $error("continuous conversion did not restart");
    compare_miss_a: assert property (st_q == ST_FINISH && tcs_q[CMPE_BIT - 4] && !cond
        |=> $stable(res_q) && !$rose(done_q))
        else $error("failed compare changed result or flag");
    hw_start_a: assert property (st_q == ST_IDLE && start && !wr_ccc && !wr_mode
        |=> st_q == ST_SAMPLE)
        else $error("hardware trigger did not start");
endmodule : adc_control
`default_nettype wire

// [adc_control_bench.sv]
// Self-checking bench for the converter control block, run alone.
// Assumes the package and the block are compiled first; assertions live in the design.
`timescale 1ns/10ps
`default_nettype none
module adc_control_bench;
    import adc_ctl_pkg::*;
    // Design connections
    logic        mclk_i;
    logic        resetn_i;
    wb_req_t     req;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        hw_trig_i;
    logic        alt_ck_en_i   = 1'b0;
    logic        async_ck_en_i = 1'b0;
    logic        cmp_i;
    logic [9:0]  dac_code_o;
    logic        sample_o;
    logic [4:0]  channel_o;
    logic        low_power_o;
    logic [15:0] pin_analog_o;
    logic        irq_o;
    // Bench model state
    int          ain;                       // Analog input in codes; beyond range saturates
    int          error_cnt = 0;
    int          n_checks  = 0;
    int          run_len   = 0;
    int          last_len  = 0;             // Length of the last sample window in cycles
    logic [9:0]  last_res  = 10'h000;       // Last result that software should still see
    logic [7:0]  q;

    adc_control adc_control_i (
        .mclk_i        (mclk_i),
        .resetn_i      (resetn_i),
        .wb_req_i      (req),
        .wb_dat_o      (wb_dat_o),
        .wb_ack_o      (wb_ack_o),
        .alt_ck_en_i   (alt_ck_en_i),
        .async_ck_en_i (async_ck_en_i),
        .hw_trig_i     (hw_trig_i),
        .cmp_i         (cmp_i),
        .dac_code_o    (dac_code_o),
        .sample_o      (sample_o),
        .channel_o     (channel_o),
        .low_power_o   (low_power_o),
        .pin_analog_o  (pin_analog_o),
        .irq_o         (irq_o)
    );

    // Ideal comparator; an unsynchronised level, as the real front end is
    assign cmp_i = (ain >= int'(dac_code_o));

    // Clock at 125 MHz
    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end

    // Alternate source ticks at random, the other source every second cycle
    always @(posedge mclk_i) begin
        alt_ck_en_i   <= 1'($urandom);
        async_ck_en_i <= ~async_ck_en_i;
    end

    // Measures each sample window so its length can be compared
    always @(posedge mclk_i) begin
        if (sample_o === 1'b1) run_len++;
        else if (run_len != 0) begin
            last_len = run_len;
            run_len  = 0;
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One classic cycle; held until ack is sampled, released at that edge
    task automatic bus(input logic we, input logic [3:0] idx, input logic [7:0] d,
                       output logic [7:0] rq);
        int t;
        @(posedge mclk_i);
        req.cyc <= 1'b1;
        req.stb <= 1'b1;
        req.we  <= we;
        req.sel <= 4'hF;
        req.adr <= {2'b00, idx, 2'b00};
        req.dat <= {24'h000000, d};
        t = 0;
        do begin
            @(posedge mclk_i);
            t++;
        end while (wb_ack_o !== 1'b1 && t < 20);
        if (wb_ack_o !== 1'b1) begin
            error_cnt++;
            $display("mismatch ack expected 1 seen %b", wb_ack_o);
        end
        rq = wb_dat_o[7:0];
        req.cyc <= 1'b0;
        req.stb <= 1'b0;
    endtask : bus

    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        logic [7:0] dummy;
        bus(1'b1, idx, d, dummy);
    endtask : wr

    task automatic rd(input logic [3:0] idx, output logic [7:0] rq);
        bus(1'b0, idx, 8'h00, rq);
    endtask : rd

    // Starts one conversion on a random channel and checks flag, irq and result
    task automatic run(input int a, input bit want, input logic [9:0] exp);
        logic [7:0] h;
        logic [7:0] r;
        logic [4:0] ch;
        int n;
        ch  = 5'($urandom_range(30, 0));
        ain <= a;
        wr(CCC_IDX, {3'b010, ch});
        n = 0;
        r = 8'h00;
        // Poll bounded; a missing flag shows up as a mismatch, not a hang
        while (r[DONE_BIT] !== 1'b1 && n < 120) begin
            rd(CCC_IDX, r);
            n++;
        end
        chk("done", 32'(r[DONE_BIT]), 32'(want));
        if (want) begin
            chk("irq", 32'(irq_o), 32'h1);
            chk("chan", 32'(channel_o), 32'(ch));
            rd(RESH_IDX, h);
            rd(RESL_IDX, r);
            chk("result", 32'({h[1:0], r}), 32'(exp));
            rd(CCC_IDX, r);
            chk("done_clr", 32'(r[DONE_BIT]), 32'h0);
            chk("irq_clr", 32'(irq_o), 32'h0);
            last_res = exp;
        end
    endtask : run

    task automatic conclude();
        if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : conclude

    // Watchdog: the whole sequence needs well under this many cycles
    initial begin
        repeat (60000) @(posedge mclk_i);
        error_cnt++;
        conclude();
    end

    // Main sequence
    initial begin
        int vals[6];
        int e;
        int f;
        void'($urandom(32'h7166A5DC));
        req       = '0;
        hw_trig_i = 1'b0;
        ain       = 0;
        resetn_i  = 1'b0;
        repeat (2) @(posedge mclk_i);
        resetn_i <= 1'b1;
        // Reset values, unmapped index included
        for (int i = 0; i < 10; i++) begin
            rd(4'(i == 9 ? 15 : i), q);
            chk("reset", 32'(q), (i == 2) ? 32'h1F : 32'h0);
        end
        chk("pins_rst", 32'(pin_analog_o), 32'h0);
        // Configuration fields and read-zero status bits
        wr(CFG_IDX, 8'h98);
        rd(CFG_IDX, q);
        chk("cfg", 32'(q), 32'h98);
        chk("lowpwr", 32'(low_power_o), 32'h1);
        wr(TCS_IDX, 8'h3C);
        rd(TCS_IDX, q);
        chk("status", 32'(q), 32'h30);
        wr(TCS_IDX, 8'h00);
        // Pin control: only the pins with set bits go analog
        e = $urandom_range(255, 0);
        wr(PIN1_IDX, 8'h02);
        wr(PIN2_IDX, 8'(e));
        @(posedge mclk_i); // Pin outputs follow the registers one cycle later
        chk("pins", 32'(pin_analog_o), 32'({8'(e), 8'h02}));
        // 10-bit long sample: saturation at both ends and random mid values
        vals = '{-1, 0, 1023, 1024, $urandom_range(1022, 1), $urandom_range(1022, 1)};
        wr(CFG_IDX, 8'h98);
        foreach (vals[i]) begin
            e = (vals[i] < 0) ? 0 : ((vals[i] > 1023) ? 1023 : vals[i]);
            run(vals[i], 1'b1, 10'(e));
            chk("long", 32'(last_len), 32'd24);
        end
        // Short sample through every divide ratio from the bus clock
        for (int d = 0; d < 4; d++) begin
            wr(CFG_IDX, {1'b0, 2'(d), 1'b0, MODE_10BIT, 2'b00});
            run(512, 1'b1, 10'h200);
            chk("short", 32'(last_len), 32'(4 << d));
        end
        // 8-bit mode on the every-other-cycle source saturates to its own full scale
        wr(CFG_IDX, 8'h03);
        run(1024, 1'b1, 10'h0FF);
        run(-1, 1'b1, 10'h000);
        // Active flag, then a compare write aborts and keeps the old result
        wr(CFG_IDX, 8'h18);
        ain <= 7;
        wr(CCC_IDX, 8'h41);
        rd(TCS_IDX, q);
        chk("active", 32'(q[ACT_BIT]), 32'h1);
        wr(CMPL_IDX, 8'h00);
        repeat (300) @(posedge mclk_i);
        rd(CCC_IDX, q);
        chk("abort", 32'(q[DONE_BIT]), 32'h0);
        rd(RESH_IDX, q);
        e = q;
        rd(RESL_IDX, q);
        chk("kept", 32'({e[1:0], q}), 32'(last_res));
        // Channel all ones: the write aborts and nothing restarts
        wr(CCC_IDX, 8'h5F);
        repeat (300) @(posedge mclk_i);
        rd(CCC_IDX, q);
        chk("off", 32'(q[DONE_BIT]), 32'h0);
        chk("off_ch", 32'(channel_o), 32'h1F);
        // Compare greater-or-equal against 0x200; only a hit completes
        wr(TCS_IDX, 8'h30);
        wr(CMPH_IDX, 8'h02);
        wr(CMPL_IDX, 8'h00);
        rd(CMPH_IDX, q);
        chk("cmp_val", 32'(q), 32'h02);
        run(256, 1'b0, 10'h000);
        run(768, 1'b1, 10'h100);
        wr(TCS_IDX, 8'h00);
        // Hardware trigger on the random alternate source: waits, then converts once
        wr(CFG_IDX, 8'h0A);
        wr(TCS_IDX, 8'h40);
        e = $urandom_range(1023, 0);
        ain <= e;
        wr(CCC_IDX, 8'h44);
        repeat (100) @(posedge mclk_i);
        rd(CCC_IDX, q);
        chk("hw_wait", 32'(q[DONE_BIT]), 32'h0);
        hw_trig_i <= 1'b1;
        @(posedge mclk_i);
        hw_trig_i <= 1'b0;
        repeat (400) @(posedge mclk_i);
        rd(CCC_IDX, q);
        chk("hw_done", 32'(q[DONE_BIT]), 32'h1);
        chk("hw_irq", 32'(irq_o), 32'h1);
        rd(RESH_IDX, q);
        f = q;
        rd(RESL_IDX, q);
        chk("hw_res", 32'({f[1:0], q}), 32'(e));
        // Continuous on the halved bus clock; a high-byte read holds the result
        wr(CFG_IDX, 8'h09);
        wr(TCS_IDX, 8'h00);
        ain <= vals[5];
        wr(CCC_IDX, 8'h23);
        repeat (300) @(posedge mclk_i);
        rd(RESH_IDX, q);
        f = q;
        ain <= 1023 - vals[5];
        repeat (300) @(posedge mclk_i);
        rd(RESL_IDX, q);
        chk("held", 32'({f[1:0], q}), 32'(vals[5]));
        repeat (300) @(posedge mclk_i);
        rd(RESH_IDX, q);
        f = q;
        rd(RESL_IDX, q);
        chk("cont", 32'({f[1:0], q}), 32'(1023 - vals[5]));
        conclude();
    end
endmodule : adc_control_bench
`default_nettype wire
